/* File: hdl/pmc_color_unit.sv */
// Purpose: Colour, mask and mix registers plus pixel write datapath.
// Assumes: One host access per cycle; pixel inputs synchronous to clk.
// Notes: One registered pipeline stage from pixel request to result.

`timescale 1ns/10ps

// Behaviour
// - Wide bit picks 32-bit or split programmed access
// - Split 32bpp access uses half picked by flag
// - Flag toggles itself after every 32bpp half access
// - Write mask bit enables its bitplane update
// - Read mask gates source planes in transfers
// - Compare enable; sense bit picks match or mismatch
// - Mix op combines new and current colour
// - Sixteen logical mix operation encodings
// - Source field picks bg, fg, CPU, memory
// - Two mix registers, reserved bits read zero
// - Colour, mask and mix registers readable and writable; misc and mix-select are write-only
// - Mix-select field chooses which mix applies
// - Upper-word flag lives at misc bit four
module pmc_color_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Host register port
  input wire logic [15:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [31:0] host_wdata,
  input wire logic host_memory_mapped_access,
  output logic [31:0] host_rdata,
  output logic host_rvalid,
  // Mode
  input wire logic pixel_32bpp,
  // Pixel request
  input wire logic pix_valid,
  input wire logic pix_transfer,
  input wire logic [31:0] pix_cpu_data,
  input wire logic [31:0] pix_mem_src,
  input wire logic [31:0] pix_dest,
  // Pixel result
  output logic pix_done,
  output logic [31:0] pix_result,
  output logic [31:0] pix_plane_en
);

  // ==========================================================
  // Storage
  logic [31:0] wide_ff [pmc_pkg::NUM_WIDE]; // Colour and mask registers
  logic [15:0] bg_mix_ff; // Background mix
  logic [15:0] fg_mix_ff; // Foreground mix
  logic [11:0] misc_ff; // Misc control low bits
  logic [1:0] mix_sel_ff; // Mix choice source
  logic [31:0] rdata_ff; // Read data
  logic rvalid_ff; // Read answer pulse
  logic [31:0] result_ff; // Merged pixel
  logic [31:0] plane_en_ff; // Planes to update
  logic done_ff; // Result valid

  // ==========================================================
  // Decode
  logic wide_hit; // Address hits a 32-bit register
  logic [2:0] wide_idx; // Which one
  logic half_mode; // Split into 16-bit halves
  logic upper_word_select; // Half flag
  logic half_seq; // Half access that steps the flag
  logic multi_wr; // Write to the indexed port
  logic [3:0] sub_idx; // Indexed register selector

  // Address to array index
  always_comb begin
    wide_hit = 1'b1;
    case (host_addr)
      pmc_pkg::OFS_BG_COLOUR: wide_idx = pmc_pkg::IDX_BG;
      pmc_pkg::OFS_FG_COLOUR: wide_idx = pmc_pkg::IDX_FG;
      pmc_pkg::OFS_WR_MASK: wide_idx = pmc_pkg::IDX_WMASK;
      pmc_pkg::OFS_RD_MASK: wide_idx = pmc_pkg::IDX_RMASK;
      pmc_pkg::OFS_CMP_COLOUR: wide_idx = pmc_pkg::IDX_CMP;
      default: begin
        wide_idx = pmc_pkg::IDX_BG;
        wide_hit = 1'b0;
      end
    endcase
  end

  // Memory-mapped access is always full width
  assign half_mode = !host_memory_mapped_access && !misc_ff[pmc_pkg::MISC_WIDE_BIT];
  assign upper_word_select = misc_ff[pmc_pkg::MISC_UWS_BIT];
  assign half_seq = half_mode && pixel_32bpp && wide_hit &&
                    (host_wr || host_rd);
  assign multi_wr = host_wr && (host_addr == pmc_pkg::OFS_MULTI);
  assign sub_idx = host_wdata[pmc_pkg::MULTI_IDX_LSB +: 4];

  // ==========================================================
  // Colour and mask register writes
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < pmc_pkg::NUM_WIDE; i++) begin
        wide_ff[i] <= pmc_pkg::WIDE_RESET;
      end
    end else if (host_wr && wide_hit) begin
      if (!half_mode) begin
        wide_ff[wide_idx] <= host_wdata;
      end else if (pixel_32bpp && upper_word_select) begin
        wide_ff[wide_idx][31:16] <= host_wdata[15:0];
      end else begin
        // Outside 32bpp only the low half is reachable
        wide_ff[wide_idx][15:0] <= host_wdata[15:0];
      end
    end
  end

  // Mix register writes keep only defined fields
  always_ff @(posedge clk) begin
    if (reset) begin
      bg_mix_ff <= pmc_pkg::MIX_RESET;
      fg_mix_ff <= pmc_pkg::MIX_RESET;
    end else if (host_wr && host_addr == pmc_pkg::OFS_BG_MIX) begin
      bg_mix_ff <= host_wdata[15:0] & pmc_pkg::MIX_RW_MASK;
    end else if (host_wr && host_addr == pmc_pkg::OFS_FG_MIX) begin
      fg_mix_ff <= host_wdata[15:0] & pmc_pkg::MIX_RW_MASK;
    end
  end

  // Misc control: software write or half-access toggle
  always_ff @(posedge clk) begin
    if (reset) begin
      misc_ff <= pmc_pkg::MISC_RESET;
    end else if (multi_wr && sub_idx == pmc_pkg::SUB_MISC) begin
      misc_ff <= host_wdata[11:0];
    end else if (half_seq) begin
      // Step to the other half so two accesses make one word
      misc_ff[pmc_pkg::MISC_UWS_BIT] <= !upper_word_select;
    end
  end

  // Pixel control mix choice field
  always_ff @(posedge clk) begin
    if (reset) begin
      mix_sel_ff <= pmc_pkg::SEL_FG;
    end else if (multi_wr && sub_idx == pmc_pkg::SUB_PIXCTL) begin
      mix_sel_ff <= host_wdata[pmc_pkg::PIXCTL_SEL_LSB +: 2];
    end
  end

  // ==========================================================
  // Read path, one cycle latency
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_ff <= 32'h0000_0000;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= host_rd;
      if (host_rd) begin
        if (wide_hit && !half_mode) begin
          rdata_ff <= wide_ff[wide_idx];
        end else if (wide_hit && pixel_32bpp && upper_word_select) begin
          rdata_ff <= {16'h0000, wide_ff[wide_idx][31:16]};
        end else if (wide_hit) begin
          rdata_ff <= {16'h0000, wide_ff[wide_idx][15:0]};
        end else if (host_addr == pmc_pkg::OFS_BG_MIX) begin
          rdata_ff <= {16'h0000, bg_mix_ff};
        end else if (host_addr == pmc_pkg::OFS_FG_MIX) begin
          rdata_ff <= {16'h0000, fg_mix_ff};
        end else begin
          // Unmapped or write-only addresses read zero
          rdata_ff <= 32'h0000_0000;
        end
      end
    end
  end

  // ==========================================================
  // Pixel datapath
  logic [31:0] src_mask; // Planes used as source
  logic [31:0] cpu_m; // Masked CPU data
  logic [31:0] mem_m; // Masked memory source
  logic pick_fg; // Foreground mix chosen
  logic [15:0] act_mix; // Applied mix register
  logic [31:0] new_colour; // Selected new colour
  logic [31:0] alu_res; // Mix result
  logic cmp_ok; // Compare permits update
  logic [31:0] wmask; // Plane write enables

  // Read mask only narrows blit and image transfer data
  assign src_mask = pix_transfer ? wide_ff[pmc_pkg::IDX_RMASK] :
                    32'hffff_ffff;
  assign cpu_m = pix_cpu_data & src_mask;
  assign mem_m = pix_mem_src & src_mask;
  assign wmask = wide_ff[pmc_pkg::IDX_WMASK];

  // Mix register choice; reserved code behaves as foreground
  always_comb begin
    case (mix_sel_ff)
      pmc_pkg::SEL_CPU: pick_fg = cpu_m[0];
      pmc_pkg::SEL_MEM: pick_fg = mem_m[0];
      default: pick_fg = 1'b1;
    endcase
  end
  assign act_mix = pick_fg ? fg_mix_ff : bg_mix_ff;

  // New colour source
  always_comb begin
    case (act_mix[pmc_pkg::MIX_SRC_LSB +: 2])
      pmc_pkg::SRC_BG: new_colour = wide_ff[pmc_pkg::IDX_BG];
      pmc_pkg::SRC_FG: new_colour = wide_ff[pmc_pkg::IDX_FG];
      pmc_pkg::SRC_CPU: new_colour = cpu_m;
      default: new_colour = mem_m;
    endcase
  end

  // Logical mix of new against current
  pmc_mix_alu u_alu (
    .op(act_mix[3:0]),
    .cur(pix_dest),
    .nw(new_colour),
    .res(alu_res)
  );

  // Sense bit set: update only on match
  assign cmp_ok = !misc_ff[pmc_pkg::MISC_CMP_EN_BIT] ||
    (misc_ff[pmc_pkg::MISC_CMP_NE_BIT] ?
     (wide_ff[pmc_pkg::IDX_CMP] == pix_dest) :
     (wide_ff[pmc_pkg::IDX_CMP] != pix_dest));

  // Result register: disabled planes keep current value
  always_ff @(posedge clk) begin
    if (reset) begin
      result_ff <= 32'h0000_0000;
      plane_en_ff <= 32'h0000_0000;
      done_ff <= 1'b0;
    end else begin
      done_ff <= pix_valid;
      if (pix_valid) begin
        result_ff <= (alu_res & wmask) | (pix_dest & ~wmask);
        plane_en_ff <= cmp_ok ? wmask : 32'h0000_0000;
      end
    end
  end

  assign host_rdata = rdata_ff;
  assign host_rvalid = rvalid_ff;
  assign pix_done = done_ff;
  assign pix_result = result_ff;
  assign pix_plane_en = plane_en_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_low_half;
    host_wr && half_seq && !upper_word_select &&
    host_addr == pmc_pkg::OFS_BG_COLOUR;
  endsequence
  sequence s_high_half;
    host_wr && half_seq && upper_word_select &&
    host_addr == pmc_pkg::OFS_BG_COLOUR;
  endsequence

  AST_WIDE_WRITE: assert property (
    host_wr && wide_hit && !half_mode |=>
    wide_ff[$past(wide_idx)] == $past(host_wdata))
    else $error("full width write not stored");
  AST_HALF_PAIR: assert property (
    s_low_half ##1 !host_wr ##1 s_high_half |=>
    wide_ff[pmc_pkg::IDX_BG] ==
    {$past(host_wdata[15:0]), $past(host_wdata[15:0], 3)})
    else $error("two halves did not form one word");
  AST_FLAG_STEP: assert property (
    half_seq && !multi_wr |=> upper_word_select != $past(upper_word_select))
    else $error("upper word flag did not toggle");
  AST_PLANE_KEEP: assert property (
    pix_valid |=> ((pix_result ^ $past(pix_dest)) & ~$past(wmask)) == 0)
    else $error("masked plane changed");
  AST_SRC_MASK: assert property (
    pix_valid && pix_transfer && act_mix[3:0] == pmc_pkg::OP_NEW &&
    act_mix[6:5] == pmc_pkg::SRC_CPU |=>
    (pix_result & $past(wmask)) ==
    ($past(pix_cpu_data & wide_ff[pmc_pkg::IDX_RMASK]) & $past(wmask)))
    else $error("read mask not applied to source");
  AST_CMP_BLOCK: assert property (
    pix_valid && misc_ff[8] && misc_ff[7] &&
    wide_ff[pmc_pkg::IDX_CMP] != pix_dest |=> pix_plane_en == 0)
    else $error("compare mismatch still updated");
  AST_NO_CMP: assert property (
    pix_valid && !misc_ff[8] |=> pix_plane_en == $past(wmask))
    else $error("plane enables wrong without compare");
  AST_MIX_ZERO: assert property (
    pix_valid && act_mix[3:0] == pmc_pkg::OP_ZERO |=>
    (pix_result & $past(wmask)) == 0 && pix_done)
    else $error("zero mix produced ones");
  AST_FG_ALWAYS: assert property (
    pix_valid && mix_sel_ff == pmc_pkg::SEL_FG &&
    fg_mix_ff[3:0] == pmc_pkg::OP_ONE |=>
    (pix_result & $past(wmask)) == $past(wmask))
    else $error("foreground mix not applied");
  AST_MIX_RSVD: assert property (
    host_rd && host_addr == pmc_pkg::OFS_FG_MIX |=>
    host_rvalid && (host_rdata & ~32'h0000_006f) == 0)
    else $error("mix reserved bits not zero");

endmodule

/* File: hdl/pmc_pkg.sv */
// Purpose: Shared constants and types of the pixel mix colour unit.
// Assumes: Host port offsets are the printed 16-bit register addresses.
// Notes: Colour and mask registers are stored in one indexed array.

package pmc_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [15:0] OFS_BG_COLOUR = 16'ha2e8;
  localparam logic [15:0] OFS_FG_COLOUR = 16'ha6e8;
  localparam logic [15:0] OFS_WR_MASK = 16'haae8;
  localparam logic [15:0] OFS_RD_MASK = 16'haee8;
  localparam logic [15:0] OFS_CMP_COLOUR = 16'hb2e8;
  localparam logic [15:0] OFS_BG_MIX = 16'hb6e8;
  localparam logic [15:0] OFS_FG_MIX = 16'hbae8;
  localparam logic [15:0] OFS_MULTI = 16'hbee8;

  // ==========================================================
  // Indices of the 32-bit register array
  localparam logic [2:0] IDX_BG = 3'h0;
  localparam logic [2:0] IDX_FG = 3'h1;
  localparam logic [2:0] IDX_WMASK = 3'h2;
  localparam logic [2:0] IDX_RMASK = 3'h3;
  localparam logic [2:0] IDX_CMP = 3'h4;
  localparam int NUM_WIDE = 5;

  // ==========================================================
  // Indexed register selector in bits 15-12 of the multi port
  localparam int MULTI_IDX_LSB = 12;
  localparam logic [3:0] SUB_MISC = 4'he;
  localparam logic [3:0] SUB_PIXCTL = 4'ha;

  // ==========================================================
  // Field positions and reset values
  localparam int MISC_WIDE_BIT = 9;
  localparam int MISC_CMP_EN_BIT = 8;
  localparam int MISC_CMP_NE_BIT = 7;
  localparam int MISC_UWS_BIT = 4;
  localparam logic [11:0] MISC_RESET = 12'h000;
  localparam int PIXCTL_SEL_LSB = 6;
  localparam int MIX_SRC_LSB = 5;
  localparam logic [15:0] MIX_RW_MASK = 16'h006f;
  localparam logic [15:0] MIX_RESET = 16'h0000;
  localparam logic [31:0] WIDE_RESET = 32'h0000_0000;

  // ==========================================================
  // Mix operation codes
  localparam logic [3:0] OP_NOT_CUR = 4'h0;
  localparam logic [3:0] OP_ZERO = 4'h1;
  localparam logic [3:0] OP_ONE = 4'h2;
  localparam logic [3:0] OP_CUR = 4'h3;
  localparam logic [3:0] OP_NOT_NEW = 4'h4;
  localparam logic [3:0] OP_XOR = 4'h5;
  localparam logic [3:0] OP_XNOR = 4'h6;
  localparam logic [3:0] OP_NEW = 4'h7;
  localparam logic [3:0] OP_NC_OR_NN = 4'h8;
  localparam logic [3:0] OP_C_OR_NN = 4'h9;
  localparam logic [3:0] OP_NC_OR_N = 4'ha;
  localparam logic [3:0] OP_C_OR_N = 4'hb;
  localparam logic [3:0] OP_C_AND_N = 4'hc;
  localparam logic [3:0] OP_NC_AND_N = 4'hd;
  localparam logic [3:0] OP_C_AND_NN = 4'he;
  localparam logic [3:0] OP_NC_AND_NN = 4'hf;

  // ==========================================================
  // Colour source and mix choice encodings
  typedef enum logic [1:0] {
    SRC_BG = 2'h0, SRC_FG = 2'h1, SRC_CPU = 2'h2, SRC_MEM = 2'h3
  } pmc_src_e;
  typedef enum logic [1:0] {
    SEL_FG = 2'h0, SEL_RSVD = 2'h1, SEL_CPU = 2'h2, SEL_MEM = 2'h3
  } pmc_sel_e;

endpackage

/* File: hdl/pmc_mix_alu.sv */
// Purpose: Bitwise logical mix of current and new pixel colour.
// Assumes: Pure combinational, one op for all bitplanes.
// Notes: Each plane is an independent 16-way selector.

`timescale 1ns/10ps

module pmc_mix_alu (
  // Operation
  input wire logic [3:0] op,
  // Operands
  input wire logic [31:0] cur,
  input wire logic [31:0] nw,
  // Result
  output logic [31:0] res
);

  // ==========================================================
  // Per-plane mix
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_plane
      // One plane of the truth table
      always_comb begin
        case (op)
          pmc_pkg::OP_NOT_CUR: res[gi] = ~cur[gi];
          pmc_pkg::OP_ZERO: res[gi] = 1'b0;
          pmc_pkg::OP_ONE: res[gi] = 1'b1;
          pmc_pkg::OP_CUR: res[gi] = cur[gi];
          pmc_pkg::OP_NOT_NEW: res[gi] = ~nw[gi];
          pmc_pkg::OP_XOR: res[gi] = cur[gi] ^ nw[gi];
          pmc_pkg::OP_XNOR: res[gi] = ~(cur[gi] ^ nw[gi]);
          pmc_pkg::OP_NEW: res[gi] = nw[gi];
          pmc_pkg::OP_NC_OR_NN: res[gi] = ~cur[gi] | ~nw[gi];
          pmc_pkg::OP_C_OR_NN: res[gi] = cur[gi] | ~nw[gi];
          pmc_pkg::OP_NC_OR_N: res[gi] = ~cur[gi] | nw[gi];
          pmc_pkg::OP_C_OR_N: res[gi] = cur[gi] | nw[gi];
          pmc_pkg::OP_C_AND_N: res[gi] = cur[gi] & nw[gi];
          pmc_pkg::OP_NC_AND_N: res[gi] = ~cur[gi] & nw[gi];
          pmc_pkg::OP_C_AND_NN: res[gi] = cur[gi] & ~nw[gi];
          pmc_pkg::OP_NC_AND_NN: res[gi] = ~cur[gi] & ~nw[gi];
          default: res[gi] = cur[gi];
        endcase
      end
    end
  endgenerate

endmodule

/* File: test/pmc_host_model.sv */
// Purpose: Host side model that drives register port cycles.
// Assumes: One access at a time, strobes one cycle wide.
// Notes: Idle write data is inverted so stale values never match.

`timescale 1ns/10ps

module pmc_host_model (
  // Clock
  input wire logic clk,
  // Host register port
  output logic [15:0] host_addr,
  output logic host_wr,
  output logic host_rd,
  output logic [31:0] host_wdata,
  output logic host_memory_mapped_access,
  input wire logic [31:0] host_rdata,
  input wire logic host_rvalid
);
  // ==========================================================
  // Idle bus at time zero
  initial begin
    host_addr = 16'h0000;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_wdata = 32'h0000_0000;
    host_memory_mapped_access = 1'b0;
  end

  // ==========================================================
  // Write: one strobe cycle, then scramble the data lines
  task automatic wr(input logic [15:0] a, input logic [31:0] d,
                    input logic m);
    @(posedge clk);
    host_addr <= a;
    host_wdata <= d;
    host_memory_mapped_access <= m;
    host_wr <= 1'b1;
    @(posedge clk);
    host_wr <= 1'b0;
    host_wdata <= ~d;
  endtask

  // Read: strobe, then wait a bounded time for the answer
  task automatic rd(input logic [15:0] a, input logic m,
                    output logic [31:0] d);
    int n;
    @(posedge clk);
    host_addr <= a;
    host_memory_mapped_access <= m;
    host_rd <= 1'b1;
    @(posedge clk);
    host_rd <= 1'b0;
    #1;
    n = 0;
    // Bounded so a dead port cannot hang the run
    while (host_rvalid !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    d = host_rdata;
  endtask
endmodule

/* File: test/pmc_color_unit_bench.sv */
// Purpose: Self-checking bench of the pixel mix colour unit.
// Assumes: Host model owns the register port; bench owns pixels.
// Notes: Expected pixels of the mix code sweep come from a local copy of the mix table.

`timescale 1ns/10ps

`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
  mismatches++; $display("unexpected %s exp %h got %h", nm, ex, got); \
  end end

module pmc_color_unit_bench;
  // ==========================================================
  // Test colours; bit 0 of cpu and memory words is set
  localparam logic [31:0] BGC = 32'h3c3c_1e1e;
  localparam logic [31:0] FGC = 32'h5a5a_c3c3;
  localparam logic [31:0] CPU = 32'h9876_5431;
  localparam logic [31:0] MEM = 32'h1357_9bdf;
  localparam logic [31:0] DST = 32'h0ff0_33cc;
  localparam logic [31:0] ONES = 32'hffff_ffff;
  logic clk, reset, host_wr, host_rd, host_memory_mapped_access, host_rvalid;
  logic [15:0] host_addr;
  logic [31:0] host_wdata, host_rdata, rdv;
  logic pixel_32bpp, pix_valid, pix_transfer, pix_done;
  logic [31:0] pix_cpu_data, pix_mem_src, pix_dest;
  logic [31:0] pix_result, pix_plane_en;
  logic [15:0] wofs [5];
  logic [31:0] srcv [4];
  int mismatches, num_checks, cycles;

  // ==========================================================
  // Instances
  pmc_color_unit pmc_color_unit_i (.clk(clk), .reset(reset),
    .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
    .host_wdata(host_wdata), .host_memory_mapped_access(host_memory_mapped_access),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .pixel_32bpp(pixel_32bpp), .pix_valid(pix_valid),
    .pix_transfer(pix_transfer), .pix_cpu_data(pix_cpu_data),
    .pix_mem_src(pix_mem_src), .pix_dest(pix_dest),
    .pix_done(pix_done), .pix_result(pix_result),
    .pix_plane_en(pix_plane_en));
  pmc_host_model pmc_host_model_i (.clk(clk), .host_addr(host_addr),
    .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
    .host_memory_mapped_access(host_memory_mapped_access), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid));

  // ==========================================================
  // Clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard; the run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      final_report();
    end
  end

  // ==========================================================
  // Helpers
  task automatic final_report();
    if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d,
                    input logic m);
    pmc_host_model_i.wr(a, d, m);
  endtask

  // Indexed port: index E is misc control, index A mix choice
  task automatic idx(input logic [3:0] i, input logic [11:0] v);
    wr(pmc_pkg::OFS_MULTI, {16'h0000, i, v}, 1'b0);
  endtask

  task automatic rchk(input logic [15:0] a, input logic m,
                      input logic [31:0] e);
    pmc_host_model_i.rd(a, m, rdv);
    `CHK("host_rvalid", 1'b1, host_rvalid);
    `CHK("host_rdata", e, rdv);
  endtask

  // One pixel request, answer checked one cycle later
  task automatic px(input logic [31:0] c, mm, d, input logic x,
                    input logic [31:0] er, ee);
    @(posedge clk);
    pix_valid <= 1'b1;
    pix_transfer <= x;
    pix_cpu_data <= c;
    pix_mem_src <= mm;
    pix_dest <= d;
    @(posedge clk);
    pix_valid <= 1'b0;
    pix_dest <= ~d;
    #1;
    `CHK("pix_done", 1'b1, pix_done);
    `CHK("pix_result", er, pix_result);
    `CHK("pix_plane_en", ee, pix_plane_en);
  endtask

  // Reference mix table, c current and n new
  function automatic logic [31:0] mix_ref(input logic [3:0] op,
                                          input logic [31:0] c, n);
    case (op)
      4'h0: return ~c;
      4'h1: return 32'h0000_0000;
      4'h2: return ONES;
      4'h3: return c;
      4'h4: return ~n;
      4'h5: return c ^ n;
      4'h6: return ~(c ^ n);
      4'h7: return n;
      4'h8: return ~c | ~n;
      4'h9: return c | ~n;
      4'ha: return ~c | n;
      4'hb: return c | n;
      4'hc: return c & n;
      4'hd: return ~c & n;
      4'he: return c & ~n;
      default: return ~c & ~n;
    endcase
  endfunction

  // ==========================================================
  // Main sequence
  initial begin
    reset = 1'b1;
    {pixel_32bpp, pix_valid, pix_transfer} = 3'h0;
    {pix_cpu_data, pix_mem_src, pix_dest} = '0;
    wofs = '{pmc_pkg::OFS_BG_COLOUR, pmc_pkg::OFS_FG_COLOUR,
      pmc_pkg::OFS_WR_MASK, pmc_pkg::OFS_RD_MASK, pmc_pkg::OFS_CMP_COLOUR};
    srcv = '{BGC, FGC, CPU, MEM};
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rchk(pmc_pkg::OFS_BG_COLOUR, 1'b1, 32'h0000_0000);
    // Full width round trip, then reserved mix bits and a hole
    for (int i = 0; i < 5; i++) begin
      wr(wofs[i], 32'h8421_7e00 | i, 1'b1);
      rchk(wofs[i], 1'b1, 32'h8421_7e00 | i);
    end
    wr(pmc_pkg::OFS_BG_MIX, ONES, 1'b1);
    rchk(pmc_pkg::OFS_BG_MIX, 1'b1, 32'h0000_006f);
    wr(pmc_pkg::OFS_FG_MIX, ONES, 1'b1);
    rchk(pmc_pkg::OFS_FG_MIX, 1'b1, 32'h0000_006f);
    rchk(16'h1234, 1'b1, 32'h0000_0000);
    // Split access outside 32bpp touches the low half only
    wr(pmc_pkg::OFS_BG_COLOUR, 32'hffff_1357, 1'b0);
    rchk(pmc_pkg::OFS_BG_COLOUR, 1'b0, 32'h0000_1357);
    rchk(pmc_pkg::OFS_BG_COLOUR, 1'b1, 32'h8421_1357);
    idx(4'he, 12'h200);
    wr(pmc_pkg::OFS_BG_COLOUR, 32'h2468_ace0, 1'b0);
    rchk(pmc_pkg::OFS_BG_COLOUR, 1'b0, 32'h2468_ace0);
    // 32bpp halves alternate under the upper word flag
    @(posedge clk);
    pixel_32bpp <= 1'b1;
    idx(4'he, 12'h000);
    wr(pmc_pkg::OFS_BG_COLOUR, 32'h0000_1111, 1'b0);
    wr(pmc_pkg::OFS_BG_COLOUR, 32'h0000_2222, 1'b0);
    rchk(pmc_pkg::OFS_BG_COLOUR, 1'b1, 32'h2222_1111);
    rchk(pmc_pkg::OFS_BG_COLOUR, 1'b0, 32'h0000_1111);
    rchk(pmc_pkg::OFS_BG_COLOUR, 1'b0, 32'h0000_2222);
    idx(4'he, 12'h010);
    rchk(pmc_pkg::OFS_BG_COLOUR, 1'b0, 32'h0000_2222);
    @(posedge clk);
    pixel_32bpp <= 1'b0;
    idx(4'he, 12'h000);
    // All sixteen mix codes with the foreground colour
    wr(pmc_pkg::OFS_WR_MASK, ONES, 1'b1);
    wr(pmc_pkg::OFS_FG_COLOUR, FGC, 1'b1);
    wr(pmc_pkg::OFS_BG_COLOUR, BGC, 1'b1);
    for (int op = 0; op < 16; op++) begin
      wr(pmc_pkg::OFS_FG_MIX, {25'h0, 2'h1, 1'b0, op[3:0]}, 1'b1);
      px(CPU, MEM, DST, 1'b0, mix_ref(op[3:0], DST, FGC), ONES);
    end
    // Partial write mask keeps disabled planes of the pixel
    wr(pmc_pkg::OFS_WR_MASK, 32'h00ff_f00f, 1'b1);
    wr(pmc_pkg::OFS_FG_MIX, 32'h0000_0025, 1'b1);
    px(CPU, MEM, DST, 1'b0, ((FGC ^ DST) & 32'h00ff_f00f) |
       (DST & 32'hff00_0ff0), 32'h00ff_f00f);
    wr(pmc_pkg::OFS_WR_MASK, ONES, 1'b1);
    for (int s = 0; s < 4; s++) begin
      wr(pmc_pkg::OFS_FG_MIX, {25'h0, s[1:0], 5'h07}, 1'b1);
      px(CPU, MEM, DST, 1'b0, srcv[s], ONES);
    end
    // Read mask only gates the source in transfers
    wr(pmc_pkg::OFS_FG_MIX, 32'h0000_0047, 1'b1);
    wr(pmc_pkg::OFS_RD_MASK, 32'h0f0f_0f0f, 1'b1);
    px(CPU, MEM, DST, 1'b1, CPU & 32'h0f0f_0f0f, ONES);
    px(CPU, MEM, DST, 1'b0, CPU, ONES);
    // Compare on match, then on mismatch
    wr(pmc_pkg::OFS_CMP_COLOUR, DST, 1'b1);
    idx(4'he, 12'h180);
    px(CPU, MEM, DST, 1'b0, CPU, ONES);
    px(CPU, MEM, ~DST, 1'b0, CPU, 32'h0000_0000);
    idx(4'he, 12'h100);
    px(CPU, MEM, DST, 1'b0, CPU, 32'h0000_0000);
    px(CPU, MEM, ~DST, 1'b0, CPU, ONES);
    // Mix choice: fg mix gives ones, bg mix gives zeros
    idx(4'he, 12'h000);
    wr(pmc_pkg::OFS_FG_MIX, 32'h0000_0002, 1'b1);
    wr(pmc_pkg::OFS_BG_MIX, 32'h0000_0001, 1'b1);
    idx(4'ha, 12'h080);
    px(CPU, MEM, DST, 1'b0, ONES, ONES);
    px(CPU ^ 32'h1, MEM, DST, 1'b0, 32'h0000_0000, ONES);
    idx(4'ha, 12'h0c0);
    px(CPU ^ 32'h1, MEM, DST, 1'b0, ONES, ONES);
    px(CPU, MEM ^ 32'h1, DST, 1'b0, 32'h0000_0000, ONES);
    idx(4'ha, 12'h000);
    px(CPU ^ 32'h1, MEM ^ 32'h1, DST, 1'b0, ONES, ONES);
    // Reserved choice code falls back to the foreground mix
    idx(4'ha, 12'h040);
    px(CPU ^ 32'h1, MEM ^ 32'h1, DST, 1'b0, ONES, ONES);
    final_report();
  end
endmodule
